// [swc_map.vh]
// register offsets, field positions and timing counts for the sleep/wake block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef SWC_MAP_VH
`define SWC_MAP_VH
`define SWC_OFF_IOC      12'h000
`define SWC_OFF_INTCTL   12'h004
`define SWC_OFF_PEN1     12'h008
`define SWC_OFF_PEN2     12'h00c
`define SWC_OFF_PFL1     12'h010
`define SWC_OFF_PFL2     12'h014
`define SWC_OFF_CFG      12'h018
`define SWC_OFF_STAT     12'h01c
`define SWC_RST_BYTE     8'h00
`define SWC_PEN2_MASK    8'h01
`define SWC_INT_GLOBAL   7
`define SWC_INT_PEIE     6
`define SWC_INT_T0IE     5
`define SWC_INT_INTE     4
`define SWC_INT_RBIE     3
`define SWC_INT_T0IF     2
`define SWC_INT_INTF     1
`define SWC_INT_RBIF     0
`define SWC_P1_TIMER_ONE 0
`define SWC_P1_CAPT_ONE  2
`define SWC_P1_SYNC_SER  3
`define SWC_P1_RC        5
`define SWC_P1_AD        6
`define SWC_CFG_WDTEN    0
`define SWC_CFG_OSC_LSB  1
`define SWC_CFG_T1ASYNC  3
`define SWC_CFG_ADRC     4
`define SWC_CFG_RCSLAVE  5
`define SWC_CFG_SSPSLV   6
`define SWC_OSC_CRYSTAL  2'h0
`define SWC_OSC_HI_SPEED 2'h1
`define SWC_OSC_LOW_PWR  2'h2
`define SWC_OSC_EXT_CLK  2'h3
`define SWC_TOSC_CYCLES  1024
`define SWC_CLK_DIV      4
`define SWC_OST_CYCLES   13'd4096
`define SWC_VECTOR       13'h0004
`endif

// [swc_sleep_wake.v]
// sleep and wake controller: apb registers, sleep entry, wake decision
// assumes core gives a one-cycle sleep strobe; async pins from outside
// Notes on behaviour
// - sleep clears watchdog when WDTEN is set, watchdog keeps running
// - sleep entry clears power-down, sets time-out
// - main oscillator off, timer one osc untouched
// - io pins hold their pre-sleep state
// - watchdog reset never drives reset pin low
// - wake on reset pin, watchdog, enabled interrupt
// - power-down set at power-up; watchdog wake clears time-out
// - timer one wakes only as async counter
// - listed peripherals may wake the device
// - other peripherals cannot interrupt during sleep
// - next instruction prefetched during sleep
// - wake needs source enable, not global enable
// - global enable picks inline resume or vector
// - pending enabled flag wakes at once
// - watchdog cleared on every wake
// - pending interrupt makes sleep a no-op
// - late interrupt: finish sleep, then wake
// - crystal modes wait start-up; external clock skips
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "swc_map.vh"
module swc_sleep_wake (
  input  wire        CLK_SYS,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        SLEEP_INSTR,
  input  wire        WATCHDOG_TIMEOUT,
  input  wire        EXT_RESET_PIN_N,
  input  wire        EXT_INT_PIN,
  input  wire [7:0]  CHANGE_PINS,
  input  wire        TIMER_ONE_EVT,
  input  wire        CAPTURE_ONE_EVT,
  input  wire        CAPTURE_TWO_EVT,
  input  wire        SERIAL_RX_EVT,
  input  wire        SYNC_SERIAL_EVT,
  input  wire        ADC_DONE_EVT,
  input  wire        OTHER_PERIPH_EVT,
  output reg         WATCHDOG_CLEAR,
  output reg         MAIN_OSC_ENABLE,
  output reg         IO_HOLD,
  output reg         PREFETCH_NEXT,
  output reg         CORE_RUN,
  output reg         CORE_VECTOR,
  output reg  [12:0] VECTOR_ADDR,
  output reg         DEVICE_RESET,
  output reg         RESET_PIN_DRIVE_LOW
);
  localparam ST_RUN   = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_OST   = 2'h2;
  localparam ST_RESUME = 2'h3;

  reg [7:0]  ioc_en;
  reg [7:0]  int_ctl;
  reg [7:0]  pen1;
  reg [7:0]  pen2;
  reg [7:0]  pfl1;
  reg [7:0]  pfl2;
  reg [6:0]  cfg;
  reg        power_down_flag;
  reg        timeout_flag;
  reg [1:0]  state;
  reg [12:0] ost_cnt;
  reg [20:0] sync_a;
  reg [20:0] sync_b;
  reg [20:0] sync_c;
  reg [31:0] next_rdata;
  wire       wr;
  wire       rd;
  wire [20:0] in_raw;
  wire       rst_pin_n;
  wire       wdt_expired;
  wire [7:0] chg;
  wire [7:0] chg_prev;
  wire       ev_int;
  wire       ev_t1;
  wire       ev_c1;
  wire       ev_c2;
  wire       ev_rx;
  wire       ev_ssp;
  wire       ev_ad;
  wire       ev_oth;
  wire       wake_req;
  wire       osc_needs_ost;
  wire       asleep;

  // pins arrive asynchronously: two flops, third stage only for edges
  assign in_raw = {OTHER_PERIPH_EVT, ADC_DONE_EVT, SYNC_SERIAL_EVT,
                   SERIAL_RX_EVT, CAPTURE_TWO_EVT, CAPTURE_ONE_EVT,
                   TIMER_ONE_EVT, EXT_INT_PIN, WATCHDOG_TIMEOUT,
                   EXT_RESET_PIN_N, CHANGE_PINS, 3'h0};
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      // reset pin idles high: no false reset request after reset
      sync_a <= 21'h000800;
      sync_b <= 21'h000800;
      sync_c <= 21'h000800;
    end else begin
      sync_a <= in_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  assign rst_pin_n = sync_b[11];
  assign wdt_expired = sync_b[12];
  assign chg       = sync_b[10:3];
  assign chg_prev  = sync_c[10:3];
  assign ev_int    = sync_b[13] & ~sync_c[13];
  assign ev_t1     = sync_b[14] & ~sync_c[14];
  assign ev_c1     = sync_b[15] & ~sync_c[15];
  assign ev_c2     = sync_b[16] & ~sync_c[16];
  assign ev_rx     = sync_b[17] & ~sync_c[17];
  assign ev_ssp    = sync_b[18] & ~sync_c[18];
  assign ev_ad     = sync_b[19] & ~sync_c[19];
  assign ev_oth    = sync_b[20] & ~sync_c[20];
  assign asleep    = (state == ST_SLEEP);

  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & PENABLE & ~PWRITE;

  // wake is pure gating, needs no running clock in silicon
  assign wake_req = (int_ctl[`SWC_INT_INTE] & int_ctl[`SWC_INT_INTF]) |
                    (int_ctl[`SWC_INT_RBIE] & int_ctl[`SWC_INT_RBIF]) |
                    (int_ctl[`SWC_INT_PEIE] &
                     (|(pen1 & pfl1) | |(pen2 & pfl2)));

  assign osc_needs_ost = (cfg[2:1] != `SWC_OSC_EXT_CLK);

  // interrupt flags: hardware set beats a software clear
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      ioc_en  <= `SWC_RST_BYTE;
      int_ctl <= `SWC_RST_BYTE;
      pen1    <= `SWC_RST_BYTE;
      pen2    <= `SWC_RST_BYTE;
      pfl1    <= `SWC_RST_BYTE;
      pfl2    <= `SWC_RST_BYTE;
      cfg     <= 7'h00;
    end else begin
      if (wr && PADDR == `SWC_OFF_IOC)
        ioc_en <= PWDATA[7:0];
      if (wr && PADDR == `SWC_OFF_INTCTL)
        int_ctl <= PWDATA[7:0];
      if (wr && PADDR == `SWC_OFF_PEN1)
        pen1 <= PWDATA[7:0];
      if (wr && PADDR == `SWC_OFF_PEN2)
        pen2 <= PWDATA[7:0] & `SWC_PEN2_MASK;
      if (wr && PADDR == `SWC_OFF_PFL1)
        pfl1 <= PWDATA[7:0];
      if (wr && PADDR == `SWC_OFF_PFL2)
        pfl2 <= PWDATA[7:0] & `SWC_PEN2_MASK;
      if (wr && PADDR == `SWC_OFF_CFG)
        cfg <= PWDATA[6:0];
      if (ev_int)
        int_ctl[`SWC_INT_INTF] <= 1'b1;
      if (|((chg ^ chg_prev) & ioc_en))
        int_ctl[`SWC_INT_RBIF] <= 1'b1;
      if (ev_t1 && (!asleep || cfg[`SWC_CFG_T1ASYNC]))
        pfl1[`SWC_P1_TIMER_ONE] <= 1'b1;
      if (ev_c1)
        pfl1[`SWC_P1_CAPT_ONE] <= 1'b1;
      if (ev_c2)
        pfl2[0] <= 1'b1;
      if (ev_ssp && (!asleep || cfg[`SWC_CFG_SSPSLV]))
        pfl1[`SWC_P1_SYNC_SER] <= 1'b1;
      if (ev_rx && (!asleep || cfg[`SWC_CFG_RCSLAVE]))
        pfl1[`SWC_P1_RC] <= 1'b1;
      if (ev_ad && (!asleep || cfg[`SWC_CFG_ADRC]))
        pfl1[`SWC_P1_AD] <= 1'b1;
      // other sources have no clock while asleep
      if (ev_oth && !asleep)
        pfl1[1] <= 1'b1;
    end
  end

  // sleep sequencer
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      state               <= ST_RUN;
      ost_cnt             <= 13'h0000;
      power_down_flag     <= 1'b1;
      timeout_flag        <= 1'b1;
      WATCHDOG_CLEAR      <= 1'b0;
      MAIN_OSC_ENABLE     <= 1'b1;
      IO_HOLD             <= 1'b0;
      PREFETCH_NEXT       <= 1'b0;
      CORE_RUN            <= 1'b1;
      CORE_VECTOR         <= 1'b0;
      VECTOR_ADDR         <= `SWC_VECTOR;
      DEVICE_RESET        <= 1'b0;
      RESET_PIN_DRIVE_LOW <= 1'b0;
    end else begin
      WATCHDOG_CLEAR <= 1'b0;
      PREFETCH_NEXT  <= 1'b0;
      CORE_VECTOR    <= 1'b0;
      DEVICE_RESET   <= 1'b0;
      case (state)
        ST_RUN: begin
          // pending interrupt turns sleep into a no-op
          if (SLEEP_INSTR && !wake_req) begin
            WATCHDOG_CLEAR  <= cfg[`SWC_CFG_WDTEN];
            power_down_flag <= 1'b0;
            timeout_flag    <= 1'b1;
            MAIN_OSC_ENABLE <= 1'b0;
            IO_HOLD         <= 1'b1;
            PREFETCH_NEXT   <= 1'b1;
            CORE_RUN        <= 1'b0;
            state           <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!rst_pin_n) begin
            DEVICE_RESET    <= 1'b1;
            WATCHDOG_CLEAR  <= 1'b1;
            MAIN_OSC_ENABLE <= 1'b1;
            state           <= ST_OST;
            ost_cnt         <= 13'h0000;
          end else if (wake_req ||
                       (wdt_expired && cfg[`SWC_CFG_WDTEN])) begin
            // late interrupt still wakes after sleep fully done
            if (wdt_expired && cfg[`SWC_CFG_WDTEN] && !wake_req)
              timeout_flag <= 1'b0;
            WATCHDOG_CLEAR  <= 1'b1;
            MAIN_OSC_ENABLE <= 1'b1;
            ost_cnt         <= 13'h0000;
            state           <= osc_needs_ost ? ST_OST : ST_RESUME;
          end
        end
        ST_OST: begin
          MAIN_OSC_ENABLE <= 1'b1;
          ost_cnt <= ost_cnt + 13'd1;
          if (ost_cnt == `SWC_OST_CYCLES - 13'd1 || !osc_needs_ost)
            state <= ST_RESUME;
        end
        ST_RESUME: begin
          IO_HOLD     <= 1'b0;
          CORE_RUN    <= 1'b1;
          CORE_VECTOR <= int_ctl[`SWC_INT_GLOBAL] & wake_req;
          state       <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // apb: zero wait states, unmapped read zero with error
  always @* begin
    next_rdata = 32'h00000000;
    case (PADDR)
      `SWC_OFF_IOC:    next_rdata = {24'h000000, ioc_en};
      `SWC_OFF_INTCTL: next_rdata = {24'h000000, int_ctl};
      `SWC_OFF_PEN1:   next_rdata = {24'h000000, pen1};
      `SWC_OFF_PEN2:   next_rdata = {24'h000000, pen2};
      `SWC_OFF_PFL1:   next_rdata = {24'h000000, pfl1};
      `SWC_OFF_PFL2:   next_rdata = {24'h000000, pfl2};
      `SWC_OFF_CFG:    next_rdata = {25'h0000000, cfg};
      `SWC_OFF_STAT:   next_rdata = {28'h0000000, state,
                                     timeout_flag, power_down_flag};
      default:         next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? next_rdata : 32'h00000000;
      PSLVERR <= PSEL & ~PENABLE & (PADDR > `SWC_OFF_STAT || PADDR[1:0] != 2'h0);
    end
  end
  wire unused_rd = rd;
endmodule

// [swc_sleep_wake_properties.sv]
// checker for the sleep/wake block, top ports only
// assumes bind onto swc_sleep_wake, one clock CLK_SYS
`timescale 1ns/1ps
module swc_sleep_wake_properties (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        SLEEP_INSTR,
  input wire logic        WATCHDOG_CLEAR,
  input wire logic        MAIN_OSC_ENABLE,
  input wire logic        IO_HOLD,
  input wire logic        PREFETCH_NEXT,
  input wire logic        CORE_RUN,
  input wire logic        CORE_VECTOR,
  input wire logic [12:0] VECTOR_ADDR,
  input wire logic        DEVICE_RESET,
  input wire logic        RESET_PIN_DRIVE_LOW
);
  logic [12:0] wait_cnt;
  // start-up span counted here: too long for a repetition
  always @(posedge CLK_SYS) begin
    if (RESET || CORE_RUN || !MAIN_OSC_ENABLE)
      wait_cnt <= 13'h0000;
    else
      wait_cnt <= wait_cnt + 13'h0001;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_enter;
    $fell(CORE_RUN) ##0 PREFETCH_NEXT;
  endsequence
  sequence s_wake;
    $rose(MAIN_OSC_ENABLE) ##0 WATCHDOG_CLEAR;
  endsequence
  AST_ENTRY_CAUSE: assert property ($fell(CORE_RUN) |-> $past(SLEEP_INSTR))
    else $error("sleep entered without a sleep strobe");
  AST_PREFETCH: assert property ($fell(CORE_RUN) |-> s_enter)
    else $error("no prefetch pulse on sleep entry");
  AST_OSC_OFF: assert property (s_enter |-> !MAIN_OSC_ENABLE)
    else $error("main oscillator still on in sleep");
  AST_HOLD: assert property (IO_HOLD == !CORE_RUN)
    else $error("io hold differs from sleep state");
  AST_WAKE_CLR: assert property ($rose(MAIN_OSC_ENABLE) |-> s_wake)
    else $error("wake without watchdog clear");
  AST_RUN_LATE: assert property ($rose(CORE_RUN) |-> $past(MAIN_OSC_ENABLE))
    else $error("core ran before oscillator settled");
  AST_STARTUP: assert property (wait_cnt <= 13'h1004)
    else $error("start-up wait too long");
  AST_VECTOR: assert property (CORE_VECTOR |-> CORE_RUN && VECTOR_ADDR == 13'h0004)
    else $error("vector pulse while stopped or bad address");
  AST_PIN: assert property (!RESET_PIN_DRIVE_LOW)
    else $error("reset pin driven low");
  AST_DEVRST: assert property (DEVICE_RESET |-> !CORE_RUN)
    else $error("device reset while running");
  AST_READY: assert property (PSEL && PENABLE |-> PREADY)
    else $error("no ready in access cycle");
endmodule
bind swc_sleep_wake swc_sleep_wake_properties chk_i (.CLK_SYS, .RESET, .PSEL,
  .PENABLE, .PREADY, .SLEEP_INSTR, .WATCHDOG_CLEAR, .MAIN_OSC_ENABLE, .IO_HOLD,
  .PREFETCH_NEXT, .CORE_RUN, .CORE_VECTOR, .VECTOR_ADDR, .DEVICE_RESET,
  .RESET_PIN_DRIVE_LOW);

// [swc_core_model.sv]
// stand-in for the core and the interrupt sources
// assumes the bench calls its tasks; lines change after clk edges only
`timescale 1ns/1ps
module swc_core_model (
  input  wire logic        clk_sys,
  output logic             sleep_instr,
  output logic [17:0]      ev
);
  initial begin
    sleep_instr = 1'b0;
    ev = '0;
  end
  // one-cycle strobe, the core runs sleep once
  task automatic sleep_op();
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
  endtask
  // held 4 cycles so the 2-flop sync sees a clean edge
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ev[i] <= 1'b0;
  endtask
endmodule

// [swc_sleep_wake_tb_top.sv]
// bench for the sleep/wake block: apb access, sleep and wake runs
// assumes swc_core_model drives strobe and events; bit 17 is the pin
`timescale 1ns/1ps
module swc_sleep_wake_tb_top;
  logic        clk_sys;
  logic        reset;
  logic        psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  wire  [31:0] prdata;
  wire  [17:0] ev;
  wire  [12:0] vaddr;
  wire         pready, pslverr, slp, wdc, osc, hold, pf, run, vec, drst, pl;
  int          n_fail = 0, n_compared = 0, n_wdc = 0, n_vec = 0, n_rst = 0;
  int          cyc;
  swc_core_model core (.clk_sys(clk_sys), .sleep_instr(slp), .ev(ev));
  swc_sleep_wake dut (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP_INSTR(slp),
    .WATCHDOG_TIMEOUT(ev[0]), .EXT_RESET_PIN_N(~ev[17]), .EXT_INT_PIN(ev[1]),
    .CHANGE_PINS(ev[16:9]), .TIMER_ONE_EVT(ev[2]), .CAPTURE_ONE_EVT(ev[3]),
    .CAPTURE_TWO_EVT(ev[4]), .SERIAL_RX_EVT(ev[5]), .SYNC_SERIAL_EVT(ev[6]),
    .ADC_DONE_EVT(ev[7]), .OTHER_PERIPH_EVT(ev[8]), .WATCHDOG_CLEAR(wdc),
    .MAIN_OSC_ENABLE(osc), .IO_HOLD(hold), .PREFETCH_NEXT(pf), .CORE_RUN(run),
    .CORE_VECTOR(vec), .VECTOR_ADDR(vaddr), .DEVICE_RESET(drst),
    .RESET_PIN_DRIVE_LOW(pl));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_wdc <= n_wdc + wdc;
    n_vec <= n_vec + vec;
    n_rst <= n_rst + drst;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) n_fail++;
    rdata = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_run(input int lim);
    cyc = 0;
    while (run !== 1'b1 && cyc < lim) begin
      @(posedge clk_sys);
      cyc++;
    end
    #1;
  endtask
  // sleep, fire one source, expect a wake or none
  task automatic nap(input int src, input logic wake, input int lim);
    int w0;
    w0 = n_wdc;
    core.sleep_op();
    @(posedge clk_sys);
    #1;
    chk("asleep", 32'h4, {29'h0, hold, osc, run});
    chk("hold", 1, hold);
    core.pulse(src);
    wait_run(lim);
    chk("woke", wake, run);
    chk("wdc", wake ? 2 : 1, n_wdc - w0);
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(40000 * 8);
    n_fail++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      apb(0, a[11:0], 0);
      chk("reset_val", 0, rdata);
    end
    apb(0, 12'h020, 0);
    chk("unmapped", 1, {31'h0, err});
    chk("unmapped_rd", 0, rdata);
    apb(1, 12'h00c, 32'hff);
    apb(0, 12'h00c, 0);
    chk("pen2", 1, rdata);
    apb(1, 12'h018, 32'h07);
    apb(1, 12'h004, 32'h10);
    core.pulse(1);
    core.sleep_op();
    repeat (3) @(posedge clk_sys);
    chk("noop_run", 1, run);
    apb(0, 12'h01c, 0);
    chk("noop_flags", 3, rdata[1:0]);
    chk("noop_wdc", 0, n_wdc);
    apb(1, 12'h004, 32'h10);
    nap(1, 1, 100);
    apb(0, 12'h01c, 0);
    chk("sleep_flags", 2, rdata[1:0]);
    chk("inline", 0, n_vec);
    apb(1, 12'h004, 32'h90);
    nap(1, 1, 100);
    chk("vectored", 1, n_vec);
    apb(1, 12'h004, 32'h40);
    nap(8, 0, 100);
    core.pulse(4);
    wait_run(100);
    chk("capture_wake", 1, run);
    apb(1, 12'h004, 32'h00);
    nap(1, 0, 100);
    core.pulse(0);
    wait_run(100);
    apb(0, 12'h01c, 0);
    chk("wd_flags", 0, {run, rdata[1:0]} ^ 3'h4);
    apb(1, 12'h018, 32'h01);
    nap(0, 1, 6000);
    chk("startup", 1, cyc > 4000);
    nap(17, 1, 6000);
    chk("dev_reset", 1, n_rst);
    close_out();
  end
endmodule
